// [dv/ddrcs_dev_model.sv]
// Behavioural memory controller that takes the setup words and answers init
`timescale 1ns/10ps
module ddrcs_dev_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_init,
  input wire logic [7:0] i_lat,
  output logic o_done,
  output logic [31:0] o_word [10],
  output logic [9:0] o_seen,
  output logic [7:0] o_inits,
  output logic o_bad
);
  logic [7:0] cnt_r;
  logic [3:0] nxt_r;
  logic busy_r;
  // One controller cycle per bench clock; the rate itself is not modelled
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_seen <= 10'h000;
      o_inits <= 8'h00;
      o_bad <= 1'b0;
      nxt_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      // Lane count and rank fields are stored as given
      if (i_wr) begin
        o_word[i_addr[3:0]] <= i_wdata;
        o_seen[i_addr[3:0]] <= 1'b1;
        // A new setup load withdraws the done level of the previous init
        o_done <= 1'b0;
        if (i_addr != 8'(nxt_r)) o_bad <= 1'b1;
        nxt_r <= (nxt_r == 4'h9) ? 4'h0 : nxt_r + 4'h1;
      end
      if (i_init) begin
        o_inits <= o_inits + 8'h01;
        // Init with words missing or not in DDR3 mode is flagged
        if (o_seen != 10'h3ff || o_word[0][0] !== 1'b1 || nxt_r != 4'h0) o_bad <= 1'b1;
        o_done <= 1'b0;
        busy_r <= 1'b1;
        cnt_r <= i_lat;
      end else if (busy_r) begin
        if (cnt_r == 8'h00) begin
          o_done <= 1'b1;
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule

// [dv/ddrcs_top_tb.sv]
// Self-checking bench for the DDR3 controller setup sequencer
`timescale 1ns/10ps
module ddrcs_top_tb;
  logic I_CLK = 1'b0;
  logic I_RST;
  logic [7:0] I_ADDR;
  logic [31:0] I_WDATA;
  logic I_WR;
  logic I_RD;
  logic [31:0] O_RDATA;
  logic O_DEV_WR;
  logic [7:0] O_DEV_ADDR;
  logic [31:0] O_DEV_WDATA;
  logic O_DEV_INIT;
  logic dev_done;
  logic [31:0] dev_word [10];
  logic [9:0] dev_seen;
  logic [7:0] dev_inits;
  logic dev_bad;
  logic [7:0] lat;
  logic [31:0] sh [10];
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  ddrcs_top uut (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_DEV_WR(O_DEV_WR),
    .O_DEV_ADDR(O_DEV_ADDR), .O_DEV_WDATA(O_DEV_WDATA), .O_DEV_INIT(O_DEV_INIT),
    .I_DEV_INIT_DONE(dev_done));
  ddrcs_dev_model dev (.i_clk(I_CLK), .i_rst(I_RST), .i_wr(O_DEV_WR), .i_addr(O_DEV_ADDR),
    .i_wdata(O_DEV_WDATA), .i_init(O_DEV_INIT), .i_lat(lat), .o_done(dev_done),
    .o_word(dev_word), .o_seen(dev_seen), .o_inits(dev_inits), .o_bad(dev_bad));
  always #2.5 I_CLK = ~I_CLK;
  task automatic wrap_up();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 chk(O_RDATA, e);
  endtask
  function automatic logic [4:0] exp_err(input logic [31:0] c, input logic [31:0] r,
      input logic all);
    exp_err = {~all, r[19:16] != 4'h8, |c[6:3], c[2] != c[1], c[0] != 1'b1};
  endfunction
  function automatic logic [31:0] st(input logic [9:0] m, input logic [4:0] e,
      input logic d, input logic b);
    st = {6'h00, m, 3'h0, e, 6'h00, d, b};
  endfunction
  // Random words with a valid config and refresh word
  task automatic load();
    for (int i = 0; i < 10; i++) sh[i] = $urandom;
    sh[0][0] = 1'b1;
    sh[0][2] = sh[0][1];
    sh[0][6:3] = 4'h0;
    sh[1][19:16] = 4'h8;
    for (int i = 0; i < 10; i++) wr(8'(i * 4), sh[i]);
  endtask
  initial begin
    I_RST = 1'b1;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 8'h00;
    I_WDATA = 32'h0;
    lat = 8'h00;
    void'($urandom(32'h87c855c1));
    repeat (5) @(posedge I_CLK);
    I_RST <= 1'b0;
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h28, 32'h0);
    sh[0] = 32'h00000001;
    wr(8'h00, sh[0]);
    wr(8'h28, 32'h1);
    rd(8'h2c, st(10'h001, exp_err(sh[0], 32'h0, 1'b0), 1'b0, 1'b0));
    for (int k = 0; k < 4; k++) begin
      load();
      case (k)
        0: sh[0][0] = 1'b0;
        1: sh[0][2] = ~sh[0][1];
        2: sh[0][3 + ($urandom % 4)] = 1'b1;
        default: sh[1][19:16] = 4'h8 ^ (4'h1 + 4'($urandom % 15));
      endcase
      wr(8'h00, sh[0]);
      wr(8'h04, sh[1]);
      wr(8'h28, 32'h2);
      wr(8'h28, 32'h1);
      rd(8'h2c, st(10'h3ff, exp_err(sh[0], sh[1], 1'b1), 1'b0, 1'b0));
    end
    chk(32'(dev_inits), 32'h0);
    for (int n = 0; n < 2; n++) begin
      lat <= 8'(n * ($urandom % 30));
      load();
      rd(8'h14, sh[5]);
      wr(8'h28, 32'h2);
      wr(8'h28, 32'h1);
      rd(8'h2c, st(10'h3ff, 5'h00, 1'b0, 1'b1));
      wr(8'h14, ~sh[5]);
      rd(8'h14, sh[5]);
      for (int t = 0; t < 200 && !(dev_done === 1'b1 && dev_inits == 8'(n + 1)); t++)
        @(posedge I_CLK);
      repeat (3) @(posedge I_CLK);
      rd(8'h2c, st(10'h3ff, 5'h00, 1'b1, 1'b0));
      for (int i = 0; i < 10; i++) chk(dev_word[i], sh[i]);
      chk(32'(dev_bad), 32'h0);
    end
    chk(32'(dev_inits), 32'h2);
    wrap_up();
  end
endmodule

// [logic/ddrcs_check.sv]
// Sanity checks on the configuration and refresh words before sending
`timescale 1ns/10ps
`include "ddrcs_defines.svh"
module ddrcs_check (
  input wire logic [31:0] i_cfg,
  input wire logic [31:0] i_ref,
  output logic [3:0] o_fault
);
  always_comb begin
    o_fault[0] = i_cfg[`DDRCS_CFG_MODE] != `DDRCS_MODE_DDR3;
    o_fault[1] = i_cfg[`DDRCS_CFG_BURST] != i_cfg[`DDRCS_CFG_WIDTH];
    o_fault[2] = i_cfg[`DDRCS_CFG_ECC] | i_cfg[`DDRCS_CFG_COR] |
                 i_cfg[`DDRCS_CFG_UNC] | i_cfg[`DDRCS_CFG_LARGE];
    o_fault[3] = i_ref[`DDRCS_REF_BL_HI:`DDRCS_REF_BL_LO] != `DDRCS_BACKLOG;
  end
endmodule

// [logic/ddrcs_defines.svh]
// Constants for the DDR3 controller setup sequencer
`ifndef DDRCS_DEFINES_SVH
`define DDRCS_DEFINES_SVH
`define DDRCS_NREG 4'ha
`define DDRCS_LAST_IDX 4'h9
`define DDRCS_ALL_MASK 10'h3ff
`define DDRCS_ONE_MASK 10'h001
`define DDRCS_CFG_IDX 4'h0
`define DDRCS_REF_IDX 4'h1
`define DDRCS_SH_LAST 8'h24
`define DDRCS_OFF_CTRL 8'h28
`define DDRCS_OFF_STAT 8'h2c
`define DDRCS_DEV_BASE 8'h00
`define DDRCS_CTRL_START 0
`define DDRCS_CTRL_CLEAR 1
`define DDRCS_ST_BUSY 0
`define DDRCS_ST_DONE 1
`define DDRCS_ST_ERR_LO 8
`define DDRCS_ST_ERR_HI 12
`define DDRCS_ST_MASK_LO 16
`define DDRCS_ST_MASK_HI 25
`define DDRCS_CFG_MODE 0
`define DDRCS_CFG_WIDTH 1
`define DDRCS_CFG_BURST 2
`define DDRCS_CFG_ECC 3
`define DDRCS_CFG_COR 4
`define DDRCS_CFG_UNC 5
`define DDRCS_CFG_LARGE 6
`define DDRCS_MODE_DDR3 1'b1
`define DDRCS_REF_BL_LO 16
`define DDRCS_REF_BL_HI 19
`define DDRCS_BACKLOG 4'h8
`endif

// [logic/ddrcs_pkg.sv]
// Types for the DDR3 controller setup sequencer
package ddrcs_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_START, ST_WAIT} ddrcs_state_type;
  typedef logic [3:0] ddrcs_idx_type;
endpackage

// [logic/ddrcs_sh_if.sv]
// Shadow register file access between the sequencer and its store
`timescale 1ns/10ps
interface ddrcs_sh_if;
  logic wr;
  ddrcs_pkg::ddrcs_idx_type widx;
  logic [31:0] wdata;
  ddrcs_pkg::ddrcs_idx_type ridx_a;
  ddrcs_pkg::ddrcs_idx_type ridx_b;
  logic [31:0] rdata_a;
  logic [31:0] rdata_b;
  logic [31:0] cfg_word;
  logic [31:0] ref_word;
  modport store(input wr, widx, wdata, ridx_a, ridx_b,
                output rdata_a, rdata_b, cfg_word, ref_word);
  modport user(output wr, widx, wdata, ridx_a, ridx_b,
               input rdata_a, rdata_b, cfg_word, ref_word);
endinterface

// [logic/ddrcs_shadow.sv]
// Shadow copies of the ten device setup words
`timescale 1ns/10ps
`include "ddrcs_defines.svh"
module ddrcs_shadow (
  input wire logic i_clk,
  input wire logic i_rst,
  ddrcs_sh_if.store sh
);
  logic [31:0] mem_r [0:9];
  logic [31:0] mem_nxt [0:9];

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (sh.wr && sh.widx < `DDRCS_NREG) begin
      mem_nxt[sh.widx] = sh.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 10; i++) begin
      if (i_rst) begin
        mem_r[i] <= 32'h0;
      end else begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  assign sh.rdata_a = (sh.ridx_a < `DDRCS_NREG) ? mem_r[sh.ridx_a] : 32'h0;
  assign sh.rdata_b = (sh.ridx_b < `DDRCS_NREG) ? mem_r[sh.ridx_b] : 32'h0;
  assign sh.cfg_word = mem_r[`DDRCS_CFG_IDX];
  assign sh.ref_word = mem_r[`DDRCS_REF_IDX];
endmodule

// [logic/ddrcs_top.sv]
// Host sequencer that loads the DDR3 controller setup words and starts init
//
// How it works
// - All ten setup words go to the controller before the init request is issued.
// - Every word, termination and second-rank ones included, must be loaded before a start.
// - The memory-type field must be 1, selecting DDR3 operation.
// - The byte-lane field is 0 for one lane and 1 for two lanes.
// - The column top-bit field carries the column bit count minus one.
// - The row top-bit field carries the row bit count minus one.
// - The transfer-width field must equal the byte-lane field.
// - Check-code, error forwarding and large-map bits stay 0 during init.
// - Refresh interval is tREFI over 3.2 ns rounded down, backlog limit is 8.
// - The power-up wait field holds the reset-exit delay in cycles minus one.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "ddrcs_defines.svh"
module ddrcs_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_DEV_WR,
  output logic [7:0] O_DEV_ADDR,
  output logic [31:0] O_DEV_WDATA,
  output logic O_DEV_INIT,
  input wire logic I_DEV_INIT_DONE
);
  ddrcs_pkg::ddrcs_state_type state_r;
  ddrcs_pkg::ddrcs_state_type state_nxt;
  ddrcs_pkg::ddrcs_idx_type idx_r;
  ddrcs_pkg::ddrcs_idx_type idx_nxt;
  logic [9:0] mask_r;
  logic [9:0] mask_nxt;
  logic [4:0] err_r;
  logic [4:0] err_nxt;
  logic done_r;
  logic done_nxt;
  logic dev_wr_r;
  logic dev_wr_nxt;
  logic [7:0] dev_addr_r;
  logic [7:0] dev_addr_nxt;
  logic [31:0] dev_wdata_r;
  logic [31:0] dev_wdata_nxt;
  logic dev_init_r;
  logic dev_init_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [3:0] fault;
  logic [31:0] stat_word;
  logic busy;
  logic wr_ctrl;
  logic start_req;
  logic clear_req;

  ddrcs_sh_if sh();

  ddrcs_shadow u_shadow (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .sh(sh.store)
  );

  ddrcs_check u_check (
    .i_cfg(sh.cfg_word),
    .i_ref(sh.ref_word),
    .o_fault(fault)
  );

  // Shadow window decode, shared by writes and reads
  function automatic logic is_shadow(input logic [7:0] a);
    is_shadow = (a <= `DDRCS_SH_LAST) && (a[1:0] == 2'h0);
  endfunction

  assign busy = state_r != ddrcs_pkg::ST_IDLE;
  assign wr_ctrl = I_WR && (I_ADDR == `DDRCS_OFF_CTRL);
  assign start_req = wr_ctrl && I_WDATA[`DDRCS_CTRL_START];
  assign clear_req = wr_ctrl && I_WDATA[`DDRCS_CTRL_CLEAR];

  // Shadow words are frozen while a load is in flight
  assign sh.wr = I_WR && is_shadow(I_ADDR) && !busy;
  assign sh.widx = I_ADDR[5:2];
  assign sh.wdata = I_WDATA;
  assign sh.ridx_a = I_ADDR[5:2];
  assign sh.ridx_b = idx_r;

  always_comb begin
    stat_word = 32'h0;
    stat_word[`DDRCS_ST_BUSY] = busy;
    stat_word[`DDRCS_ST_DONE] = done_r;
    stat_word[`DDRCS_ST_ERR_HI:`DDRCS_ST_ERR_LO] = err_r;
    stat_word[`DDRCS_ST_MASK_HI:`DDRCS_ST_MASK_LO] = mask_r;
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    dev_wr_nxt = 1'b0;
    dev_addr_nxt = dev_addr_r;
    dev_wdata_nxt = dev_wdata_r;
    dev_init_nxt = 1'b0;
    mask_nxt = mask_r;
    if (sh.wr) begin
      mask_nxt = mask_r | (`DDRCS_ONE_MASK << sh.widx);
    end
    err_nxt = clear_req ? 5'h00 : err_r;
    done_nxt = clear_req ? 1'b0 : done_r;
    case (state_r)
      ddrcs_pkg::ST_IDLE: begin
        if (start_req) begin
          // Error set is applied after the clear, so it wins
          if (fault != 4'h0 || mask_r != `DDRCS_ALL_MASK) begin
            err_nxt = err_nxt | {mask_r != `DDRCS_ALL_MASK, fault};
          end else begin
            state_nxt = ddrcs_pkg::ST_SEND;
            idx_nxt = 4'h0;
            done_nxt = 1'b0;
          end
        end
      end
      ddrcs_pkg::ST_SEND: begin
        dev_wr_nxt = 1'b1;
        dev_addr_nxt = `DDRCS_DEV_BASE + {4'h0, idx_r};
        // Fields are forwarded exactly as software loaded them
        dev_wdata_nxt = sh.rdata_b;
        if (idx_r == `DDRCS_LAST_IDX) begin
          state_nxt = ddrcs_pkg::ST_START;
        end else begin
          idx_nxt = idx_r + 4'h1;
        end
      end
      ddrcs_pkg::ST_START: begin
        dev_init_nxt = 1'b1;
        state_nxt = ddrcs_pkg::ST_WAIT;
      end
      ddrcs_pkg::ST_WAIT: begin
        if (I_DEV_INIT_DONE) begin
          done_nxt = 1'b1;
          state_nxt = ddrcs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = ddrcs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_r <= ddrcs_pkg::ST_IDLE;
      idx_r <= 4'h0;
      mask_r <= 10'h000;
      err_r <= 5'h00;
      done_r <= 1'b0;
      dev_wr_r <= 1'b0;
      dev_addr_r <= 8'h00;
      dev_wdata_r <= 32'h0;
      dev_init_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      mask_r <= mask_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      dev_wr_r <= dev_wr_nxt;
      dev_addr_r <= dev_addr_nxt;
      dev_wdata_r <= dev_wdata_nxt;
      dev_init_r <= dev_init_nxt;
    end
  end

  // Read data for the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0;
    if (I_RD) begin
      if (is_shadow(I_ADDR)) begin
        rdata_nxt = sh.rdata_a;
      end else if (I_ADDR == `DDRCS_OFF_STAT) begin
        rdata_nxt = stat_word;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign O_RDATA = rdata_r;
  assign O_DEV_WR = dev_wr_r;
  assign O_DEV_ADDR = dev_addr_r;
  assign O_DEV_WDATA = dev_wdata_r;
  assign O_DEV_INIT = dev_init_r;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_cfg_write;
    dev_wr_r && (dev_addr_r == `DDRCS_DEV_BASE + {4'h0, `DDRCS_CFG_IDX});
  endsequence

  sequence s_ref_write;
    dev_wr_r && (dev_addr_r == `DDRCS_DEV_BASE + {4'h0, `DDRCS_REF_IDX});
  endsequence

  sequence s_two_writes;
    dev_wr_r ##1 dev_wr_r;
  endsequence

  a_init_after_last: assert property (
    $rose(dev_init_r) |-> $past(dev_wr_r) &&
      ($past(dev_addr_r) == `DDRCS_DEV_BASE + {4'h0, `DDRCS_LAST_IDX}))
    else $error("init issued before the last setup word");

  a_first_word_cfg: assert property (
    $rose(dev_wr_r) |-> dev_addr_r == `DDRCS_DEV_BASE + {4'h0, `DDRCS_CFG_IDX}
      ##9 dev_wr_r ##1 (!dev_wr_r && dev_init_r))
    else $error("setup load not ten words followed by init");

  a_mode_ddr3: assert property (
    s_cfg_write |-> dev_wdata_r[`DDRCS_CFG_MODE] == `DDRCS_MODE_DDR3)
    else $error("memory type not DDR3 when sent");

  a_lane_match: assert property (
    s_cfg_write |-> dev_wdata_r[`DDRCS_CFG_BURST] == dev_wdata_r[`DDRCS_CFG_WIDTH])
    else $error("transfer width differs from lane count");

  a_check_code_off: assert property (
    s_cfg_write |-> !(dev_wdata_r[`DDRCS_CFG_ECC] || dev_wdata_r[`DDRCS_CFG_COR] ||
      dev_wdata_r[`DDRCS_CFG_UNC] || dev_wdata_r[`DDRCS_CFG_LARGE]))
    else $error("check code or map bits set during init");

  a_backlog_eight: assert property (
    s_ref_write |-> dev_wdata_r[`DDRCS_REF_BL_HI:`DDRCS_REF_BL_LO] == `DDRCS_BACKLOG)
    else $error("refresh backlog limit not eight");

  a_addr_step: assert property (
    s_two_writes |-> dev_addr_r == $past(dev_addr_r) + 8'h01)
    else $error("setup words not sent in order");

  a_refuse_fault: assert property (
    (state_r == ddrcs_pkg::ST_IDLE && start_req && fault != 4'h0)
      |=> (state_r == ddrcs_pkg::ST_IDLE && err_r[3:0] != 4'h0) ##1
      state_r == ddrcs_pkg::ST_IDLE)
    else $error("faulty configuration was not refused");

  a_stat_read: assert property (
    (I_RD && I_ADDR == `DDRCS_OFF_STAT) |=> O_RDATA == $past(stat_word))
    else $error("status read data wrong");
endmodule
